/* File: common/dmem_decode_pkg.sv */
// shared constants and carrier types for the data memory address decoder
package dmem_decode_pkg;

   // ---------------------------------------------------------------
   // address map
   // ---------------------------------------------------------------
   localparam logic [15:0] PERIPH_RAM_LO = 16'hfc80;
   localparam logic [15:0] PERIPH_RAM_HI = 16'hfdff;
   localparam logic [15:0] MAIN_RAM_LO = 16'hfe00;
   localparam logic [15:0] MAIN_RAM_HI = 16'hfeff;
   localparam logic [15:0] SPECIAL_LO = 16'hff00;
   localparam logic [15:0] SHORT_BASE = 16'hfe20;
   localparam logic [7:0] SPECIAL_PAGE = 8'hff;
   localparam logic [15:0] ROM_HI = 16'h3fff;
   localparam int MAIN_RAM_BYTES = 256;
   localparam int PERIPH_RAM_BYTES = 384;

   // ---------------------------------------------------------------
   // general register file
   // ---------------------------------------------------------------
   localparam int BANK_COUNT = 8;
   localparam int BANK_BYTES = 16;
   localparam logic [7:0] GREG_RESET = 8'h00;
   localparam logic [15:0] PREFETCH_RESET = 16'h0000;

   typedef enum logic [2:0] {
      MODE_PHYS = 3'h1,
      MODE_SHORT = 3'h2,
      MODE_SPECIAL = 3'h4
   } addr_mode_t;

   typedef enum logic [4:0] {
      TGT_NONE = 5'h01,
      TGT_ROM = 5'h02,
      TGT_PERIPH = 5'h04,
      TGT_MAIN = 5'h08,
      TGT_SPECIAL = 5'h10
   } target_t;

   // operand request from the execution unit
   typedef struct packed {
      logic valid;
      addr_mode_t mode;
      logic [15:0] addr;
      logic [7:0] operand;
      logic word;
      logic write;
      logic [15:0] wdata;
   } mem_req_t;

   // decoded bus cycle towards the memories
   typedef struct packed {
      logic valid;
      logic prefetch;
      target_t target;
      logic [15:0] addr;
      logic word;
      logic write;
      logic [15:0] wdata;
   } bus_cyc_t;

   // general register request
   typedef struct packed {
      logic valid;
      logic word;
      logic write;
      logic [3:0] spec;
      logic [15:0] wdata;
   } greg_req_t;

endpackage

/* File: src/dmem_decode.sv */
// data memory address decoder, general register banks and prefetch source
//
// Function
// - internal RAM sits at fc80-feff, special registers at ff00-ffff.
// - short direct byte operand maps into fe20 to ff1f.
// - short direct word with even operand touches even and next odd byte.
// - special addressing uses operand as low byte, upper byte ff.
// - special register word access pairs even and odd bytes likewise.
// - eight banks, each sixteen byte registers or eight word registers.
// - register chosen from specifier, bank select flags and register set flag.
// - rom bypass pin asserted disables on-chip ROM access.
// - 256-byte fast main RAM separate from 384-byte peripheral RAM.
// - serve execution unit requests; otherwise prefetch into instruction queue.
`timescale 1ns/1ns
module dmem_decode (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // pin and status word
   input wire logic i_rom_bypass_pin,
   input wire logic [2:0] i_bank_select_flags,
   input wire logic i_register_set_flag,
   // execution unit side
   input wire dmem_decode_pkg::mem_req_t i_req,
   output logic o_req_ready,
   input wire dmem_decode_pkg::greg_req_t i_greg,
   output logic [15:0] o_greg_rdata,
   // bus cycle and instruction queue side
   output dmem_decode_pkg::bus_cyc_t o_cyc,
   input wire logic i_queue_ready
);

   // ---------------------------------------------------------------
   // decode functions
   // ---------------------------------------------------------------
   function automatic logic [15:0] eff_addr(input dmem_decode_pkg::mem_req_t r);
      logic [15:0] a;
      a = r.addr;
      unique case (r.mode)
         dmem_decode_pkg::MODE_SHORT: a = 16'(dmem_decode_pkg::SHORT_BASE + {8'h00, r.operand});
         dmem_decode_pkg::MODE_SPECIAL: a = {dmem_decode_pkg::SPECIAL_PAGE, r.operand};
         dmem_decode_pkg::MODE_PHYS: a = r.addr;
         default: a = r.addr;
      endcase
      return a;
   endfunction

   function automatic dmem_decode_pkg::target_t map_addr(input logic [15:0] a,
                                                          input logic bypass);
      dmem_decode_pkg::target_t t;
      if (a >= dmem_decode_pkg::SPECIAL_LO) begin
         t = dmem_decode_pkg::TGT_SPECIAL;
      // 256-byte main window above 384-byte peripheral window
      end else if (a >= dmem_decode_pkg::MAIN_RAM_LO) begin
         t = dmem_decode_pkg::TGT_MAIN;
      end else if (a >= dmem_decode_pkg::PERIPH_RAM_LO) begin
         t = dmem_decode_pkg::TGT_PERIPH;
      end else if (a <= dmem_decode_pkg::ROM_HI && !bypass) begin
         t = dmem_decode_pkg::TGT_ROM;
      end else begin
         t = dmem_decode_pkg::TGT_NONE;
      end
      return t;
   endfunction

   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   logic bypass_meta_q, bypass_q;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         bypass_meta_q <= 1'b0;
         bypass_q <= 1'b0;
      end else begin
         bypass_meta_q <= i_rom_bypass_pin;
         bypass_q <= bypass_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // bus cycle unit
   // ---------------------------------------------------------------
   dmem_decode_pkg::bus_cyc_t cyc_q, cyc_d;
   logic [15:0] pf_q, pf_d;
   logic [15:0] ea;
   logic stall;

   assign ea = eff_addr(i_req);
   assign stall = cyc_q.valid && cyc_q.prefetch && !i_queue_ready;
   assign o_req_ready = !stall;
   assign o_cyc = cyc_q;

   always_comb begin
      cyc_d = cyc_q;
      pf_d = pf_q;
      if (!stall) begin
         // operand access has priority over prefetch
         if (i_req.valid) begin
            cyc_d.valid = 1'b1;
            cyc_d.prefetch = 1'b0;
            cyc_d.target = map_addr(ea, bypass_q);
            // word starts at even byte, pairs with odd; same for specials
            cyc_d.addr = {ea[15:1], 1'b0};
            cyc_d.word = i_req.word;
            cyc_d.write = i_req.write;
            cyc_d.wdata = i_req.wdata;
         end else begin
            cyc_d.valid = 1'b1;
            cyc_d.prefetch = 1'b1;
            cyc_d.target = map_addr(pf_q, bypass_q);
            cyc_d.addr = pf_q;
            cyc_d.word = 1'b0;
            cyc_d.write = 1'b0;
            cyc_d.wdata = 16'h0000;
            pf_d = 16'(pf_q + 16'h0001);
         end
         if (!i_req.word) begin
            cyc_d.addr = i_req.valid ? ea : cyc_d.addr;
         end
      end
   end

   // single clock domain at the divided system rate
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cyc_q <= '{valid: 1'b0, prefetch: 1'b0, target: dmem_decode_pkg::TGT_NONE,
                    addr: 16'h0000, word: 1'b0, write: 1'b0, wdata: 16'h0000};
         pf_q <= dmem_decode_pkg::PREFETCH_RESET;
      end else begin
         cyc_q <= cyc_d;
         pf_q <= pf_d;
      end
   end

   // ---------------------------------------------------------------
   // general register banks
   // ---------------------------------------------------------------
   localparam int GREG_BYTES = dmem_decode_pkg::BANK_COUNT * dmem_decode_pkg::BANK_BYTES;
   logic [7:0] greg_q [GREG_BYTES];
   logic [7:0] greg_d [GREG_BYTES];
   logic [6:0] gidx;
   logic [3:0] gsel;

   // set flag swaps register halves, bank flags pick bank
   assign gsel = i_greg.word ? {i_greg.spec[2:0] ^ {i_register_set_flag, 2'b00}, 1'b0}
                             : {i_greg.spec[3] ^ i_register_set_flag, i_greg.spec[2:0]};
   assign gidx = {i_bank_select_flags, gsel};

   // byte or word view of each bank
   always_comb begin
      greg_d = greg_q;
      if (i_greg.valid && i_greg.write) begin
         greg_d[gidx] = i_greg.wdata[7:0];
         if (i_greg.word) begin
            greg_d[7'(gidx + 7'h01)] = i_greg.wdata[15:8];
         end
      end
   end

   generate
      for (genvar g = 0; g < GREG_BYTES; g++) begin : g_greg
         always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               greg_q[g] <= dmem_decode_pkg::GREG_RESET;
            end else begin
               greg_q[g] <= greg_d[g];
            end
         end
      end
   endgenerate

   assign o_greg_rdata = i_greg.word ? {greg_q[7'(gidx + 7'h01)], greg_q[gidx]}
                                     : {8'h00, greg_q[gidx]};

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_special_target;
      @(posedge i_clk) disable iff (!i_nrst)
      (!stall && i_req.valid && i_req.mode == dmem_decode_pkg::MODE_SPECIAL)
         |=> (o_cyc.target == dmem_decode_pkg::TGT_SPECIAL && o_cyc.addr[15:8] == 8'hff);
   endproperty
   a_special_target: assert property (p_special_target) else $error("special addr bad");

   property p_short_range;
      @(posedge i_clk) disable iff (!i_nrst)
      (!stall && i_req.valid && i_req.mode == dmem_decode_pkg::MODE_SHORT)
         |=> (o_cyc.addr >= 16'hfe20 && o_cyc.addr <= 16'hff1f);
   endproperty
   a_short_range: assert property (p_short_range) else $error("short addr out of range");

   property p_word_even;
      @(posedge i_clk) disable iff (!i_nrst)
      (o_cyc.valid && o_cyc.word) |-> !o_cyc.addr[0];
   endproperty
   a_word_even: assert property (p_word_even) else $error("word cycle odd");

   property p_special_word;
      @(posedge i_clk) disable iff (!i_nrst)
      (!stall && i_req.valid && i_req.word && i_req.mode == dmem_decode_pkg::MODE_SPECIAL)
         |=> (o_cyc.word && o_cyc.addr == {8'hff, $past(i_req.operand[7:1]), 1'b0});
   endproperty
   a_special_word: assert property (p_special_word) else $error("special word pair");

   property p_map;
      @(posedge i_clk) disable iff (!i_nrst)
      (o_cyc.valid && o_cyc.addr >= 16'hfc80) |->
         (o_cyc.target == (o_cyc.addr >= 16'hff00 ? dmem_decode_pkg::TGT_SPECIAL :
          o_cyc.addr >= 16'hfe00 ? dmem_decode_pkg::TGT_MAIN : dmem_decode_pkg::TGT_PERIPH));
   endproperty
   a_map: assert property (p_map) else $error("window decode wrong");

   property p_rom_off;
      @(posedge i_clk) disable iff (!i_nrst)
      ($past(bypass_q) && o_cyc.valid) |-> o_cyc.target != dmem_decode_pkg::TGT_ROM;
   endproperty
   a_rom_off: assert property (p_rom_off) else $error("rom reached while bypassed");

   property p_prefetch_idle;
      @(posedge i_clk) disable iff (!i_nrst)
      (!stall && !i_req.valid) |=> (o_cyc.valid && o_cyc.prefetch && !o_cyc.write);
   endproperty
   a_prefetch_idle: assert property (p_prefetch_idle) else $error("no prefetch");

   property p_req_first;
      @(posedge i_clk) disable iff (!i_nrst)
      (!stall && i_req.valid) |=> (o_cyc.valid && !o_cyc.prefetch);
   endproperty
   a_req_first: assert property (p_req_first) else $error("request lost");

   property p_one_target;
      @(posedge i_clk) disable iff (!i_nrst)
      o_cyc.valid |-> $onehot(o_cyc.target);
   endproperty
   a_one_target: assert property (p_one_target) else $error("target not one-hot");

   property p_greg_write;
      @(posedge i_clk) disable iff (!i_nrst)
      (i_greg.valid && i_greg.write && !i_greg.word) |=> greg_q[$past(gidx)] == $past(i_greg.wdata[7:0]);
   endproperty
   a_greg_write: assert property (p_greg_write) else $error("register write lost");

   c_short_word: cover property (@(posedge i_clk) disable iff (!i_nrst)
      i_req.valid && i_req.word && i_req.mode == dmem_decode_pkg::MODE_SHORT);
   c_prefetch_stall: cover property (@(posedge i_clk) disable iff (!i_nrst) stall);
   c_greg_word: cover property (@(posedge i_clk) disable iff (!i_nrst)
      i_greg.valid && i_greg.word && i_register_set_flag);

endmodule

/* File: sim/exec_unit_model.sv */
// execution unit model that offers operand requests to the decoder
`timescale 1ns/1ns
module exec_unit_model (
   // clock
   input wire logic i_clk,
   // decoder handshake
   input wire logic i_req_ready,
   output dmem_decode_pkg::mem_req_t o_req
);
   logic rdy_s;
   // ready settles long before the rising edge, so look at it midway
   always @(negedge i_clk) begin
      rdy_s = i_req_ready;
   end
   initial begin
      o_req = '0;
   end
   // offer one request and hold it until the edge that takes it
   task automatic issue(input dmem_decode_pkg::addr_mode_t m, input logic [15:0] a,
         input logic [7:0] op, input logic w, input logic wr, input logic [15:0] wd);
      o_req.valid = 1'b1;
      o_req.mode = m;
      o_req.addr = w ? {a[15:1], 1'b0} : a;
      o_req.operand = w ? {op[7:1], 1'b0} : op;
      o_req.word = w;
      o_req.write = wr;
      o_req.wdata = wd;
      do @(posedge i_clk); while (rdy_s !== 1'b1);
      #1;
   endtask
   // withdraw: fields no longer show the last request
   task automatic release_req();
      o_req = {1'b0, ~o_req[$bits(o_req)-2:0]};
   endtask
endmodule

/* File: sim/dmem_decode_bench.sv */
// self-checking bench for the data memory address decoder
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dmem_decode_bench;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic bypass = 1'b0;
   logic [2:0] bank = 3'h0;
   logic set_flag = 1'b0;
   logic queue_ready = 1'b1;
   dmem_decode_pkg::mem_req_t req;
   dmem_decode_pkg::greg_req_t greg = '0;
   dmem_decode_pkg::bus_cyc_t cyc;
   logic req_ready;
   logic [15:0] greg_rdata;
   logic [15:0] p;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [7:0] regs [128];
   logic [15:0] map_tab [10] = '{16'h0000, 16'h3fff, 16'h4000, 16'hfc7f, 16'hfc80,
      16'hfdff, 16'hfe00, 16'hfeff, 16'hff00, 16'hffff};
   dmem_decode_pkg::addr_mode_t modes [3] = '{dmem_decode_pkg::MODE_PHYS,
      dmem_decode_pkg::MODE_SHORT, dmem_decode_pkg::MODE_SPECIAL};

   always #20 i_clk = ~i_clk;

   dmem_decode dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_rom_bypass_pin(bypass),
      .i_bank_select_flags(bank), .i_register_set_flag(set_flag), .i_req(req),
      .o_req_ready(req_ready), .i_greg(greg), .o_greg_rdata(greg_rdata), .o_cyc(cyc),
      .i_queue_ready(queue_ready));
   exec_unit_model eu (.i_clk(i_clk), .i_req_ready(req_ready), .o_req(req));

   // ------------------------------------------------------------
   // expectations
   // ------------------------------------------------------------
   function automatic logic [15:0] exp_addr(dmem_decode_pkg::addr_mode_t m, logic [15:0] a,
         logic [7:0] op, logic w);
      logic [15:0] r;
      case (m)
         dmem_decode_pkg::MODE_SHORT: r = dmem_decode_pkg::SHORT_BASE + {8'h00, op};
         dmem_decode_pkg::MODE_SPECIAL: r = {dmem_decode_pkg::SPECIAL_PAGE, op};
         default: r = a;
      endcase
      if (w) r[0] = 1'b0;
      return r;
   endfunction
   function automatic dmem_decode_pkg::target_t exp_tgt(logic [15:0] a, logic byp);
      if (a <= 16'h3fff) return byp ? dmem_decode_pkg::TGT_NONE : dmem_decode_pkg::TGT_ROM;
      if (a >= 16'hfc80 && a <= 16'hfdff) return dmem_decode_pkg::TGT_PERIPH;
      if (a >= 16'hfe00 && a <= 16'hfeff) return dmem_decode_pkg::TGT_MAIN;
      if (a >= 16'hff00) return dmem_decode_pkg::TGT_SPECIAL;
      return dmem_decode_pkg::TGT_NONE;
   endfunction
   function automatic int gidx(logic w, logic [3:0] s);
      return {bank, w ? {s[2] ^ set_flag, s[1:0], 1'b0} : {s[3] ^ set_flag, s[2:0]}};
   endfunction

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic access(input dmem_decode_pkg::addr_mode_t m, input logic [15:0] a,
         input logic [7:0] op, input logic w, input logic wr, input logic [15:0] wd);
      logic [15:0] ea;
      eu.issue(m, a, op, w, wr, wd);
      ea = exp_addr(m, a, op, w);
      `CHK(cyc.valid, 1'b1)
      `CHK(cyc.prefetch, 1'b0)
      `CHK(cyc.addr, ea)
      `CHK(cyc.target, exp_tgt(ea, bypass))
      `CHK({cyc.word, cyc.write}, {w, wr})
      if (wr && w) `CHK(cyc.wdata, wd)
   endtask
   task automatic greg_op(input logic w, input logic wr, input logic [3:0] s,
         input logic [15:0] d);
      int i;
      i = gidx(w, s);
      greg = '{valid: 1'b1, word: w, write: wr, spec: s, wdata: d};
      #1;
      if (!wr) `CHK(greg_rdata, w ? {regs[i+1], regs[i]} : {8'h00, regs[i]})
      @(posedge i_clk);
      #1;
      if (wr) regs[i] = d[7:0];
      if (wr && w) regs[i+1] = d[15:8];
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'heb73));
      foreach (regs[k]) regs[k] = dmem_decode_pkg::GREG_RESET;
      // reset is low from time zero with no falling edge, so the first clock applies it
      @(posedge i_clk);
      #1;
      `CHK({cyc.valid, cyc.target, req_ready}, {1'b0, dmem_decode_pkg::TGT_NONE, 1'b1})
      @(posedge i_clk);
      #1 i_nrst = 1'b1;
      @(posedge i_clk);
      #1 `CHK({cyc.prefetch, cyc.addr}, {1'b1, 16'h0000})
      queue_ready = 1'b0;
      @(posedge i_clk);
      // the refused prefetch of the first address stands while the queue is full
      #1 `CHK({cyc.prefetch, cyc.addr}, {1'b1, 16'h0000})
      `CHK(req_ready, 1'b0)
      p = cyc.addr;
      fork
         access(dmem_decode_pkg::MODE_SHORT, 16'h0000, 8'h10, 1'b0, 1'b0, 16'h0000);
         begin
            repeat (2) @(posedge i_clk);
            #1 `CHK(cyc.addr, p)
            queue_ready = 1'b1;
         end
      join
      $display("test prefetch done");
      foreach (map_tab[k]) access(dmem_decode_pkg::MODE_PHYS, map_tab[k], 8'h00, 1'b0,
         1'b0, 16'h0000);
      for (int k = 0; k < 4; k++) access(modes[k % 2 + 1], 16'h0000, {8{k[0]}}, k[1],
         1'b1, 16'h5aa5);
      eu.release_req();
      bypass = 1'b1;
      repeat (3) @(posedge i_clk);
      #1 access(dmem_decode_pkg::MODE_PHYS, 16'h3fff, 8'h00, 1'b0, 1'b0, 16'h0000);
      eu.release_req();
      bypass = 1'b0;
      repeat (3) @(posedge i_clk);
      #1 $display("test map done");
      for (int k = 0; k < 40; k++) access(modes[$urandom % 3], 16'($urandom), 8'($urandom),
         1'($urandom), 1'($urandom), 16'($urandom));
      eu.release_req();
      @(posedge i_clk);
      #1 p = cyc.addr;
      @(posedge i_clk);
      #1 `CHK({cyc.prefetch, cyc.addr}, {1'b1, 16'(p + 16'h0001)})
      $display("test random access done");
      for (int k = 0; k < 60; k++) begin
         bank = 3'($urandom);
         set_flag = 1'($urandom);
         greg_op(1'($urandom), k < 4 ? 1'b0 : 1'($urandom), 4'($urandom), 16'($urandom));
      end
      $display("test general registers done");
      conclude();
   end
endmodule
